// ===== logic/aes_map.svh
// angle encoder spi link: timing counts, frame layout and word tags
// assumes a 200 MHz system clock on both ends; included by bare name
`ifndef AES_MAP_SVH
`define AES_MAP_SVH

// system clock period and rounding of least times up to whole cycles
`define AES_CLK_NS 5
`define AES_CYC_MIN(ns) (((ns) + `AES_CLK_NS - 1) / `AES_CLK_NS)

// times in their own units
`define AES_T_BOOT_MS   16
`define AES_T_RESYNC_US 300
`define AES_T_SYNC_US   1500
`define AES_T_SOFT_S    1
`define AES_T_BIT_NS    2300
`define AES_T_BYTE_NS   12500
`define AES_T_CMD_NS    15000
`define AES_T_LEAD_NS   2300
`define AES_T_TAIL_NS   2300

// the same times as clock counts
`define AES_BOOT_CYC   `AES_CYC_MIN(`AES_T_BOOT_MS * 1000000)
`define AES_RESYNC_CYC `AES_CYC_MIN(`AES_T_RESYNC_US * 1000)
`define AES_SYNC_CYC   `AES_CYC_MIN(`AES_T_SYNC_US * 1000)
`define AES_SOFT_CYC   `AES_CYC_MIN(`AES_T_SOFT_S * 1000000000)
`define AES_HALF_CYC   ((`AES_CYC_MIN(`AES_T_BIT_NS) + 1) / 2)
`define AES_BYTE_CYC   `AES_CYC_MIN(`AES_T_BYTE_NS)
`define AES_CMD_CYC    `AES_CYC_MIN(`AES_T_CMD_NS)
`define AES_LEAD_CYC   `AES_CYC_MIN(`AES_T_LEAD_NS)
`define AES_TAIL_CYC   `AES_CYC_MIN(`AES_T_TAIL_NS)

// frame layout in bit positions, bit 0 first on the wire
`define AES_FRAME_BITS 80
`define AES_LATCH_BIT  15
`define AES_DATA_FIRST 16
`define AES_DATA_LAST  47

// command bytes and word tags in bits 1:0
`define AES_CMD       8'hAA
`define AES_CMD_INV   8'h55
`define AES_TAG_ANGLE 2'h1
`define AES_TAG_ERR   2'h2

`endif

// ===== logic/aes_pkg.sv
// angle encoder spi link: shared types of both ends
// assumes nothing beyond a SystemVerilog tool
package aes_pkg;

  // device end states, one-hot
  typedef enum logic [3:0] {
    DS_BOOT  = 4'h1,
    DS_WSYNC = 4'h2,
    DS_LINK  = 4'h4,
    DS_DEAD  = 4'h8
  } aes_dstate_t;

  // master end states, one-hot
  typedef enum logic [7:0] {
    HS_BOOT = 8'h01,
    HS_SYNC = 8'h02,
    HS_IDLE = 8'h04,
    HS_LEAD = 8'h08,
    HS_HI   = 8'h10,
    HS_LO   = 8'h20,
    HS_GAP  = 8'h40,
    HS_TAIL = 8'h80
  } aes_hstate_t;

  // reportable converter faults, in error word order from bit 10 down
  typedef struct packed {
    logic supply_over_limit_flag;
    logic offset_clip_flag;
    logic gain_above_trim_flag;
    logic field_strong_flag;
    logic field_weak_flag;
    logic gain_below_trim_flag;
    logic converter_saturation_flag;
    logic converter_failure_flag;
  } aes_fault_t;

endpackage

// ===== logic/aes_if.sv
// angle encoder spi link: select, serial clock and one open-drain data wire
// assumes an external pull-up; the wire is low only while someone pulls
`timescale 1ns/1ps
interface aes_if;
  logic sclk;
  logic ss_n;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic sda;

  // pull-up resolution of the shared wire
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));

  modport dev (
    input  sclk,
    input  ss_n,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output sclk,
    output ss_n,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );
endinterface

// ===== logic/aes_dev.sv
// angle encoder spi slave: device end of the shared-wire link
// assumes aes_if on the link side and a free-running clk_i;
// the serial clock may stand still outside frames
//
// What this block does
// - device shifts on rise, master samples falling
// - shared open-drain wire, device only pulls low
// - ignore link for 16 ms after start
// - wire released until select goes low
// - select high 300 us restarts frame
// - master resyncs with select high 1.5 ms
// - link enabled only after first resync
// - master bit period 2.3 us, bytes 12.5 us
// - master waits 2.3 us around clock edges
// - master gap 15 us after command byte
// - wire released within 1 us of deselect
// - master sends AAh then nine FFh
// - reply FF FF word inverse four FF
// - angle latched at last edge before data
// - angle word: angle bits 15:2, tag 01
// - error word tagged by bits 1:0 = 10
// - error bits 2..7 carry converter faults
// - error bits 9, 10 carry two more faults; others zero
// - latest angle held, readable any time
// - soft failure resets after 1 s or frame
// - hard failure: reset, link stays down
// - frames any time; resync before first
// - other internal errors: wire stays released
`timescale 1ns/1ps
`include "aes_map.svh"
module aes_dev
  import aes_pkg::*;
#(
  parameter int unsigned BOOT_CYC   = `AES_BOOT_CYC,
  parameter int unsigned RESYNC_CYC = `AES_RESYNC_CYC,
  parameter int unsigned SOFT_CYC   = `AES_SOFT_CYC
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial link
  aes_if.dev               link,
  // converter side
  input  wire logic        angle_stb_i,
  input  wire logic [13:0] angle_i,
  input  wire aes_fault_t  fault_i,
  input  wire logic        hard_fail_i,
  input  wire logic        other_fail_i,
  // status
  output logic             link_up_o,
  output logic             err_mode_o,
  output logic             dead_o
);

  localparam logic [6:0] LAST_BIT   = 7'(`AES_FRAME_BITS - 1);
  localparam logic [6:0] LATCH_BIT  = 7'(`AES_LATCH_BIT);
  localparam logic [6:0] DATA_FIRST = 7'(`AES_DATA_FIRST);
  localparam logic [6:0] DATA_LAST  = 7'(`AES_DATA_LAST);

  // system domain
  aes_dstate_t state_r;
  aes_dstate_t state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] hi_cnt_r;
  logic        ss_m_r;
  logic        ss_s_r;
  logic        sync_hi;
  logic        frame_clr_r;
  logic [13:0] angle_r;
  aes_fault_t  fault_r;
  logic        err_sent_r;
  logic [15:0] snap_r;
  logic        req_m_r;
  logic        req_s_r;
  logic        req_p_r;
  logic        done_m_r;
  logic        done_s_r;
  logic        done_p_r;
  logic        bit_m_r;
  logic        bit_s_r;
  logic        req_ev;
  logic        done_ev;
  logic        hard;
  logic        soft_rst;
  // serial clock domain
  logic [6:0]  cnt_r;
  logic [31:0] sh_r;
  logic        bit_r;
  logic        req_t_r;
  logic        done_t_r;

  // word sent in bytes 2 and 3: angle or error, told apart by bits 1:0
  function automatic logic [15:0] word_of(input logic       err,
                                          input logic [13:0] ang,
                                          input aes_fault_t f);
    logic [15:0] w;
    w = {ang, `AES_TAG_ANGLE};
    if (err) begin
      // bits 15:11 unused, 8 and 14 never set
      w = {5'h00, f.supply_over_limit_flag, f.offset_clip_flag, 1'b0,
           f[5:0], `AES_TAG_ERR};
    end
    return w;
  endfunction

  assign hard     = hard_fail_i || other_fail_i;
  assign sync_hi  = (hi_cnt_r == RESYNC_CYC);
  assign req_ev   = req_s_r ^ req_p_r;
  assign done_ev  = done_s_r ^ done_p_r;
  // an error frame that went out, or the long timer, ends the failure
  assign soft_rst = err_mode_o && ((done_ev && err_sent_r) ||
                                   (tmr_r == SOFT_CYC - 1));

  // two-flop synchronisers; the event toggles add a third flop to find their edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_m_r   <= 1'b1;
      ss_s_r   <= 1'b1;
      req_m_r  <= 1'b0;
      req_s_r  <= 1'b0;
      req_p_r  <= 1'b0;
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
      done_p_r <= 1'b0;
      bit_m_r  <= 1'b1;
      bit_s_r  <= 1'b1;
    end else begin
      ss_m_r   <= link.ss_n;
      ss_s_r   <= ss_m_r;
      req_m_r  <= req_t_r;
      req_s_r  <= req_m_r;
      req_p_r  <= req_s_r;
      done_m_r <= done_t_r;
      done_s_r <= done_m_r;
      done_p_r <= done_s_r;
      bit_m_r  <= bit_r;
      bit_s_r  <= bit_m_r;
    end
  end

  // start-up blanking, first resync, soft and hard failure paths
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DS_BOOT: begin
        if (tmr_r == BOOT_CYC - 1) state_nxt = DS_WSYNC;
      end
      DS_WSYNC: begin
        if (sync_hi) state_nxt = DS_LINK;
      end
      DS_LINK: begin
        if (soft_rst) state_nxt = DS_BOOT;
      end
      DS_DEAD: begin
        state_nxt = DS_DEAD;
      end
      default: begin
        state_nxt = DS_BOOT;
      end
    endcase
    if (hard) state_nxt = DS_DEAD;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= DS_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one timer serves the blanking interval and the failure timeout
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_r <= 32'h0000_0000;
    end else if (state_nxt != state_r) begin
      tmr_r <= 32'h0000_0000;
    end else if (state_r == DS_BOOT || (state_r == DS_LINK && err_mode_o)) begin
      tmr_r <= tmr_r + 32'h0000_0001;
    end else begin
      tmr_r <= 32'h0000_0000;
    end
  end

  // select-high length; select is not looked at while blanked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt_r <= 32'h0000_0000;
    end else if (!ss_s_r || state_r == DS_BOOT || state_r == DS_DEAD) begin
      hi_cnt_r <= 32'h0000_0000;
    end else if (!sync_hi) begin
      hi_cnt_r <= hi_cnt_r + 32'h0000_0001;
    end
  end

  // frame position held cleared while the link is down or select is long
  // high; this works in mid-byte too, whatever came before
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_clr_r <= 1'b1;
    end else begin
      frame_clr_r <= (state_r != DS_LINK) || sync_hi || hard;
    end
  end

  // newest angle is kept; converter rate is not tied to the bus
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      angle_r <= 14'h0000;
    end else if (angle_stb_i) begin
      angle_r <= angle_i;
    end
  end

  // reportable faults while linked turn the word into an error word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_mode_o <= 1'b0;
      fault_r    <= '0;
    end else if (state_r != DS_LINK || soft_rst) begin
      err_mode_o <= 1'b0;
      fault_r    <= '0;
    end else if (!err_mode_o && (|fault_i)) begin
      err_mode_o <= 1'b1;
      fault_r    <= fault_i;
    end
  end

  // snapshot on the latch request; the serial side reads it over
  // 12 us later, so the word is quiet when it crosses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      snap_r     <= 16'hFFFF;
      err_sent_r <= 1'b0;
    end else begin
      if (req_ev) begin
        snap_r <= word_of(err_mode_o, angle_r, fault_r);
      end
      // set wins: a snapshot in error mode marks the frame as an error one
      if (req_ev && err_mode_o) begin
        err_sent_r <= 1'b1;
      end else if (!err_mode_o) begin
        err_sent_r <= 1'b0;
      end
    end
  end

  // open-drain pin: output fixed low, enable pulls the wire
  // released within three clocks of select rising
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.dev_sda_o  <= 1'b0;
      link.dev_sda_oe <= 1'b0;
    end else begin
      link.dev_sda_o  <= 1'b0;
      link.dev_sda_oe <= (state_r == DS_LINK) && !frame_clr_r &&
                         !ss_s_r && !bit_s_r;
    end
  end

  // status outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_up_o <= 1'b0;
      dead_o    <= 1'b0;
    end else begin
      link_up_o <= (state_r == DS_LINK);
      dead_o    <= (state_r == DS_DEAD);
    end
  end

  // serial side: one bit out per rising edge, 80 bits per frame
  always_ff @(posedge link.sclk or posedge frame_clr_r) begin
    if (frame_clr_r) begin
      cnt_r <= 7'h00;
      sh_r  <= 32'hFFFF_FFFF;
      bit_r <= 1'b1;
    end else begin
      cnt_r <= (cnt_r == LAST_BIT) ? 7'h00 : cnt_r + 7'h01;
      if (cnt_r == DATA_FIRST) begin
        bit_r <= snap_r[15];
        sh_r  <= {snap_r[14:0], ~snap_r, 1'b1};
      end else if (cnt_r > DATA_FIRST && cnt_r <= DATA_LAST) begin
        bit_r <= sh_r[31];
        sh_r  <= {sh_r[30:0], 1'b1};
      end else begin
        bit_r <= 1'b1;
      end
    end
  end

  // event toggles live on the system reset only, so a frame restart
  // never fakes an edge on the other side
  always_ff @(posedge link.sclk or posedge rst_i) begin
    if (rst_i) begin
      req_t_r  <= 1'b0;
      done_t_r <= 1'b0;
    end else if (!frame_clr_r) begin
      if (cnt_r == LATCH_BIT) begin
        req_t_r <= ~req_t_r;
      end
      if (cnt_r == LAST_BIT) begin
        done_t_r <= ~done_t_r;
      end
    end
  end

endmodule

// ===== logic/aes_host.sv
// angle encoder spi master: drives select and a divided serial clock
// assumes aes_if on the link side and an external pull-up on the wire
`timescale 1ns/1ps
`include "aes_map.svh"
module aes_host
  import aes_pkg::*;
#(
  parameter int unsigned BOOT_CYC = `AES_BOOT_CYC,
  parameter int unsigned SYNC_CYC = `AES_SYNC_CYC,
  parameter logic [7:0]  CMD      = `AES_CMD
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial link
  aes_if.host              link,
  // requests
  input  wire logic        go_i,
  input  wire logic        resync_i,
  // answers
  output logic             ready_o,
  output logic             done_o,
  output logic             word_ok_o,
  output logic             word_err_o,
  output logic [15:0]      word_o
);

  localparam int unsigned HALF_CYC = `AES_HALF_CYC;
  localparam int unsigned LEAD_CYC = `AES_LEAD_CYC;
  localparam int unsigned TAIL_CYC = `AES_TAIL_CYC;
  localparam logic [6:0]  LAST_BIT = 7'(`AES_FRAME_BITS - 1);
  localparam logic [6:0]  D_FIRST  = 7'(`AES_DATA_FIRST);
  localparam logic [6:0]  D_LAST   = 7'(`AES_DATA_LAST);

  aes_hstate_t state_r;
  logic [31:0] tmr_r;
  logic [31:0] gap_r;
  logic [6:0]  bit_r;
  logic [31:0] rx_r;
  logic        sda_m_r;
  logic        sda_s_r;
  logic        do_rise;

  // command bits go out msb first in byte 0; a zero pulls the wire
  function automatic logic cmd_low(input logic [6:0] b);
    return (b < 7'h08) && !CMD[~b[2:0]];
  endfunction

  // next rising edge after lead-in, a low half or a byte gap
  assign do_rise = (state_r == HS_LEAD && tmr_r == LEAD_CYC - 1) ||
                   (state_r == HS_LO   && tmr_r == HALF_CYC - 1) ||
                   (state_r == HS_GAP  && tmr_r == gap_r - 1);

  // wire level passes two flops before it is sampled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  // frame sequencer; select stays high from reset so the device blanks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r          <= HS_BOOT;
      tmr_r            <= 32'h0000_0000;
      gap_r            <= 32'h0000_0000;
      bit_r            <= 7'h00;
      rx_r             <= 32'h0000_0000;
      link.sclk        <= 1'b0;
      link.ss_n        <= 1'b1;
      link.host_sda_o  <= 1'b0;
      link.host_sda_oe <= 1'b0;
      ready_o          <= 1'b0;
      done_o           <= 1'b0;
      word_o           <= 16'h0000;
      word_ok_o        <= 1'b0;
      word_err_o       <= 1'b0;
    end else begin
      tmr_r  <= tmr_r + 32'h0000_0001;
      done_o <= 1'b0;
      if (do_rise) begin
        link.sclk        <= 1'b1;
        link.host_sda_oe <= cmd_low(bit_r);
        tmr_r            <= 32'h0000_0000;
        state_r          <= HS_HI;
      end else begin
        case (state_r)
          HS_BOOT: begin
            if (tmr_r == BOOT_CYC - 1) begin
              tmr_r   <= 32'h0000_0000;
              state_r <= HS_SYNC;
            end
          end
          HS_SYNC: begin
            // resync before the first frame covers an undefined start
            if (tmr_r == SYNC_CYC - 1) begin
              ready_o <= 1'b1;
              state_r <= HS_IDLE;
            end
          end
          HS_IDLE: begin
            if (go_i) begin
              link.ss_n <= 1'b0;
              tmr_r     <= 32'h0000_0000;
              bit_r     <= 7'h00;
              ready_o   <= 1'b0;
              state_r   <= HS_LEAD;
            end else if (resync_i) begin
              tmr_r   <= 32'h0000_0000;
              ready_o <= 1'b0;
              state_r <= HS_SYNC;
            end
          end
          HS_HI: begin
            if (tmr_r == HALF_CYC - 1) begin
              // falling edge: sample the wire
              link.sclk        <= 1'b0;
              link.host_sda_oe <= 1'b0;
              tmr_r            <= 32'h0000_0000;
              bit_r            <= bit_r + 7'h01;
              if (bit_r >= D_FIRST && bit_r <= D_LAST) begin
                rx_r <= {rx_r[30:0], sda_s_r};
              end
              if (bit_r == LAST_BIT) begin
                state_r <= HS_TAIL;
              end else if (bit_r[2:0] == 3'h7) begin
                gap_r   <= (bit_r == 7'h07) ? `AES_CMD_CYC : `AES_BYTE_CYC;
                state_r <= HS_GAP;
              end else begin
                state_r <= HS_LO;
              end
            end
          end
          HS_TAIL: begin
            if (tmr_r == TAIL_CYC - 1) begin
              link.ss_n  <= 1'b1;
              word_o     <= rx_r[31:16];
              word_ok_o  <= (rx_r[31:16] == ~rx_r[15:0]);
              word_err_o <= (rx_r[17:16] == `AES_TAG_ERR);
              done_o     <= 1'b1;
              ready_o    <= 1'b1;
              state_r    <= HS_IDLE;
            end
          end
          HS_LEAD, HS_LO, HS_GAP: begin
            state_r <= state_r;
          end
          default: begin
            state_r <= HS_BOOT;
          end
        endcase
      end
    end
  end

endmodule

// ===== tb/aes_link_sva.sv
// angle encoder spi link: concurrent checks on the shared-wire interface
// assumes both ends sit on one aes_if and share the same clk_i
`timescale 1ns/1ps
`include "aes_map.svh"
module aes_link_sva (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic sda
);
  localparam int HALF = `AES_HALF_CYC;
  localparam int TAIL = `AES_TAIL_CYC;
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles the serial clock stood high; saturates so long idles never wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt_r <= 16'h0000;
    end else begin
      hi_cnt_r <= !sclk ? 16'h0000 : ((&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 16'h0001);
    end
  end

  // cycles the serial clock stood low, same saturation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_cnt_r <= 16'h0000;
    end else begin
      lo_cnt_r <= sclk ? 16'h0000 : ((&lo_cnt_r) ? lo_cnt_r : lo_cnt_r + 16'h0001);
    end
  end

  // open-drain pins: either end may only pull low
  a_dev_pull_only : assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device pin drives high");
  a_host_pull_only : assert property (host_sda_oe |-> !host_sda_o)
    else $error("host pin drives high");
  a_wire_low : assert property ((dev_sda_oe && !dev_sda_o) |-> !sda)
    else $error("wire not low while device pulls");
  // release well inside the deselect bound
  a_release_desel : assert property (ss_n [*4] |-> !dev_sda_oe)
    else $error("device holds wire while deselected");
  // device only shifts after a rising serial edge
  a_oe_hold_low : assert property ((!ss_n && !sclk) [*4] |=> $stable(dev_sda_oe))
    else $error("device pin moved while serial clock low");
  // the level that counts is the one just before the fall, when the host may let go
  a_sample_stable : assert property ($fell(sclk) |-> ($past(sda, 1) == $past(sda, 8)))
    else $error("wire moved just before the sampling edge");
  a_sclk_idle : assert property (ss_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_bit_high : assert property ($fell(sclk) |-> (hi_cnt_r >= HALF))
    else $error("serial clock high phase too short");
  a_bit_low : assert property ($rose(sclk) |-> (lo_cnt_r >= HALF))
    else $error("serial clock low phase too short");
  a_tail_time : assert property ($rose(ss_n) |-> (lo_cnt_r >= TAIL))
    else $error("deselect too soon after last edge");

  c_frame_end : cover property ($rose(ss_n));
  c_dev_pull : cover property (dev_sda_oe && !sda);
  c_low_sample : cover property ($fell(sclk) && !sda);
endmodule

// ===== tb/tb.sv
// angle encoder spi link: both ends face each other, bench drives user sides
// assumes short boot, resync and soft-reset counts so the run stays brief
`timescale 1ns/1ps
module tb;
  logic                clk_i, rst_i, hrst, go_i, angle_stb_i, hard_fail_i, other_fail_i;
  logic [13:0]         angle_i;
  aes_pkg::aes_fault_t fault_i;
  logic                link_up_o, err_mode_o, dead_o, ready_o, done_o, word_ok_o, word_err_o;
  logic [15:0]         word_o;
  logic [79:0]         cap;
  logic [15:0]         w_exp;
  logic [7:0]          exp_b [10];
  logic                oe_seen;
  logic                resync_i;
  logic                sda_pre;
  int                  ncap, k;
  int                  err_count = 0;
  int                  comparisons = 0;

  aes_if aif ();
  // soft timer outlasts a frame cut at bit 32 but ends well before a full one
  aes_dev #(.BOOT_CYC(200), .RESYNC_CYC(100), .SOFT_CYC(24000)) aes_dev_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(aif.dev), .angle_stb_i(angle_stb_i),
    .angle_i(angle_i), .fault_i(fault_i), .hard_fail_i(hard_fail_i),
    .other_fail_i(other_fail_i), .link_up_o(link_up_o), .err_mode_o(err_mode_o),
    .dead_o(dead_o));
  // host reset is separate so a frame can be cut off mid-byte
  aes_host #(.BOOT_CYC(200), .SYNC_CYC(150)) aes_host_i (
    .clk_i(clk_i), .rst_i(rst_i | hrst), .link(aif.host), .go_i(go_i), .resync_i(resync_i),
    .ready_o(ready_o), .done_o(done_o), .word_ok_o(word_ok_o), .word_err_o(word_err_o),
    .word_o(word_o));
  aes_link_sva aes_link_sva_i (
    .clk_i(clk_i), .rst_i(rst_i | hrst), .sclk(aif.sclk), .ss_n(aif.ss_n),
    .dev_sda_o(aif.dev_sda_o), .dev_sda_oe(aif.dev_sda_oe), .host_sda_o(aif.host_sda_o),
    .host_sda_oe(aif.host_sda_oe), .sda(aif.sda));

  // 200 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // wire level just before each system edge; the host lets go of the wire
  // at the same edge that lowers the serial clock, so sample ahead of it
  always @(posedge clk_i) sda_pre = aif.sda;

  // wire as the master sees it, first bit ends up on top
  always @(negedge aif.sclk) begin
    cap = {cap[78:0], sda_pre};
    ncap = ncap + 1;
  end

  // any device pull at all, for the dead-device frame
  always @(posedge clk_i) if (aif.dev_sda_oe === 1'b1) oe_seen = 1'b1;

  // frames of about 58k and 13k cycles plus the 24k soft timer, which covers the 22k cut frame: near 97k
  initial begin
    #(100000 * 5);
    $display("ERROR watchdog expired");
    err_count++;
    finish_test();
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_cap(input int n);
    for (k = 0; k < 70000 && ncap < n; k++) cyc(1);
  endtask

  task automatic go();
    ncap = 0;
    go_i = 1'b1;
    cyc(1);
    go_i = 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1; hrst = 1'b0; go_i = 1'b0; angle_stb_i = 1'b0; angle_i = 14'h2D3B;
    fault_i = '0; hard_fail_i = 1'b0; other_fail_i = 1'b0; ncap = 0; cap = '0; oe_seen = 1'b0;
    resync_i = 1'b0;
    cyc(5);
    rst_i = 1'b0;
    cyc(100);
    chk("link_up_o boot", link_up_o, 0);
    angle_stb_i = 1'b1;
    cyc(1);
    angle_stb_i = 1'b0;
    for (k = 0; k < 2000 && ready_o !== 1'b1; k++) cyc(1);
    chk("link_up_o sync", link_up_o, 1);
    w_exp = {angle_i, 2'b01};
    exp_b = '{8'hAA, 8'hFF, w_exp[15:8], w_exp[7:0], ~w_exp[15:8], ~w_exp[7:0],
              8'hFF, 8'hFF, 8'hFF, 8'hFF};
    // new angle after the latch edge must not reach this frame
    go();
    wait_cap(16);
    angle_i = 14'h0155;
    angle_stb_i = 1'b1;
    cyc(1);
    angle_stb_i = 1'b0;
    for (k = 0; k < 70000 && done_o !== 1'b1; k++) cyc(1);
    chk("word_o", word_o, w_exp);
    chk("word_ok_o", word_ok_o, 1);
    chk("word_err_o", word_err_o, 0);
    chk("bit count", ncap, 80);
    for (int r = 0; r < 10; r++) chk("frame byte", cap[79-8*r -: 8], exp_b[r]);
    // soft failure: error word, then reset by the timer after an aborted frame
    fault_i = 8'hA5;
    cyc(5);
    chk("err_mode_o", err_mode_o, 1);
    w_exp = {5'h00, fault_i[7:6], 1'b0, fault_i[5:0], 2'b10};
    go();
    wait_cap(32);
    chk("error word", cap[15:0], w_exp);
    chk("link_up_o held", link_up_o, 1);
    hrst = 1'b1;
    fault_i = '0;
    cyc(5);
    hrst = 1'b0;
    for (k = 0; k < 10000 && link_up_o !== 1'b0; k++) cyc(1);
    chk("link_up_o soft reset", link_up_o, 0);
    chk("err_mode_o cleared", err_mode_o, 0);
    for (k = 0; k < 3000 && (ready_o !== 1'b1 || link_up_o !== 1'b1); k++) cyc(1);
    chk("link_up_o relink", link_up_o, 1);
    // host resync: select held high for its sync count, device stays linked
    resync_i = 1'b1;
    cyc(1);
    resync_i = 1'b0;
    cyc(1);
    chk("ready_o resync", ready_o, 0);
    chk("ss_n resync", aif.ss_n, 1);
    for (k = 0; k < 300 && ready_o !== 1'b1; k++) cyc(1);
    chk("resync length", (k > 140 && k < 160), 1);
    chk("link_up_o resync", link_up_o, 1);
    // hard failure: dead, wire never pulled even where a zero bit is due
    hard_fail_i = 1'b1;
    cyc(1);
    hard_fail_i = 1'b0;
    cyc(3);
    chk("dead_o", dead_o, 1);
    chk("link_up_o dead", link_up_o, 0);
    oe_seen = 1'b0;
    go();
    wait_cap(17);
    chk("wire released", oe_seen, 0);
    hrst = 1'b1;
    cyc(5);
    hrst = 1'b0;
    rst_i = 1'b1;
    cyc(5);
    rst_i = 1'b0;
    cyc(10);
    other_fail_i = 1'b1;
    cyc(1);
    other_fail_i = 1'b0;
    cyc(3);
    chk("dead_o other", dead_o, 1);
    finish_test();
  end
endmodule
